// ==== core/flash_status_pkg.sv ====
// Purpose: Constants and types for the serial flash status register logic
// Assumes: Status bytes are eight bits and go out most significant bit first
// Notes: Opcodes are the serial command bytes taken right after chip select falls
// Operation
// - Status byte repeats with fresh contents
// - Chip select release ends read, output floats
// - Chip select may rise at any bit
// - Drive field bits 6:5, resets to 11
// - Third byte bits 7 and 4:0 zero
// - Write status changes only read-write bits
// - Protection 00: writes need only latch set
// - Protection 01, pin low: writes refused; with quad enable set the code ignores the pin and the latch allows writes
// - Protection 01, pin high: latch allows writes
// - Protection 10 locks until power cycle
// - Block bits steer array protection region
// - Latch clear ignores program, erase, status writes
// - Latch clears at power-up and reset
// - Latch clears on disable, completion or abort
// - Incomplete opcode leaves latch set
// - Busy flag follows internal operation
// - Locked security page refuses program, erase
// - Suspend during erase sets erase flag
// - Suspend during program sets program flag
// - Quad enable turns protect, hold into data
// - After bit 0 restart at bit 7
package flash_status_pkg;
	localparam logic [7:0] OP_RD1 = 8'h05;
	localparam logic [7:0] OP_RD2 = 8'h35;
	localparam logic [7:0] OP_RD3 = 8'h15;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_WR1 = 8'h01;
	localparam logic [7:0] OP_WR2 = 8'h31;
	localparam logic [7:0] OP_WR3 = 8'h11;
	localparam logic [7:0] OP_SUSP = 8'h75;
	localparam logic [7:0] OP_RESM = 8'h7A;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_QPP = 8'h32;
	localparam logic [7:0] OP_SECP = 8'h42;
	localparam logic [7:0] OP_SE4 = 8'h20;
	localparam logic [7:0] OP_BE32 = 8'h52;
	localparam logic [7:0] OP_BE64 = 8'hD8;
	localparam logic [7:0] OP_SECE = 8'h44;
	localparam logic [7:0] OP_CE1 = 8'h60;
	localparam logic [7:0] OP_CE2 = 8'hC7;
	localparam logic [7:0] SR1_RW = 8'hFC;
	localparam logic [7:0] SR2_RW = 8'h7B;
	localparam logic [7:0] SR3_RW = 8'h60;
	localparam logic [7:0] SR2_LOCKS = 8'h38;
	localparam logic [7:0] SR1_RST = 8'h00;
	localparam logic [7:0] SR2_RST = 8'h00;
	localparam logic [7:0] SR3_RST = 8'h60;
	localparam int B_LO = 7;
	localparam int B_GRAN = 6;
	localparam int B_TB = 5;
	localparam int B_AMT_HI = 4;
	localparam int B_AMT_LO = 2;
	localparam int B_WEL = 1;
	localparam int B_BUSY = 0;
	localparam int B_ESUS = 7;
	localparam int B_INV = 6;
	localparam int B_LB3 = 5;
	localparam int B_LB1 = 3;
	localparam int B_PSUS = 2;
	localparam int B_QE = 1;
	localparam int B_HI = 0;
	localparam int B_DRV_HI = 6;
	localparam int B_DRV_LO = 5;
	localparam int B_PAGE_HI = 5;
	localparam int B_PAGE_LO = 4;
	localparam int LEN_W = 6;
	localparam logic [LEN_W-1:0] LEN_OP = 6'h08;
	localparam logic [LEN_W-1:0] LEN_B1 = 6'h10;
	localparam logic [LEN_W-1:0] LEN_B2 = 6'h18;
	localparam logic [LEN_W-1:0] LEN_ADDR = 6'h20;
	localparam logic [LEN_W-1:0] LEN_PROG = 6'h28;
	localparam logic [LEN_W-1:0] LEN_MAX = 6'h3F;
	localparam logic [2:0] IDX_MSB = 3'h7;
	typedef enum logic [3:0] {
		SEL_NONE = 4'h1,
		SEL_SR1 = 4'h2,
		SEL_SR2 = 4'h4,
		SEL_SR3 = 4'h8
	} rd_sel_t;
	typedef struct packed {
		logic protect_invert;
		logic protect_granularity_sel;
		logic protect_top_bottom_sel;
		logic [2:0] protect_amount;
	} prot_cfg_t;
	typedef struct packed {
		logic [7:0] sr1;
		logic [7:0] sr2;
		logic [7:0] sr3;
	} status_t;
endpackage

// ==== core/flash_status_regs.sv ====
// Purpose: Status bytes, write protection and latch logic of a serial flash
// Assumes: SPI mode 0; serial clock stops while chip select is high
// Notes: Frame words are read by the system side only after chip select has risen
`timescale 1ns/1ps
module flash_status_regs (
	// Clocks and reset
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic spi_clk,
	// Serial pins
	input wire logic cs_n,
	input wire logic si,
	output logic so_o,
	output logic so_oe,
	input wire logic wp_n_i,
	output logic wp_n_o,
	output logic wp_n_oe,
	input wire logic hold_n_i,
	output logic hold_n_o,
	output logic hold_n_oe,
	// Quad data path, serial clock domain
	input wire logic [1:0] quad_dout,
	input wire logic quad_doe,
	// Array engine, system clock domain
	input wire logic busy_in,
	input wire logic erase_active,
	input wire logic prog_active,
	input wire logic op_end,
	output logic array_start,
	output logic [7:0] array_op,
	output flash_status_pkg::prot_cfg_t protect_cfg,
	output logic [1:0] drive_strength_sel,
	output logic quad_io_enable
);
	function automatic flash_status_pkg::rd_sel_t rsel_of(input logic [7:0] op);
		case (op)
			flash_status_pkg::OP_RD1: rsel_of = flash_status_pkg::SEL_SR1;
			flash_status_pkg::OP_RD2: rsel_of = flash_status_pkg::SEL_SR2;
			flash_status_pkg::OP_RD3: rsel_of = flash_status_pkg::SEL_SR3;
			default: rsel_of = flash_status_pkg::SEL_NONE;
		endcase
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
		input logic [7:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	function automatic logic is_erase(input logic [7:0] op);
		is_erase = (op == flash_status_pkg::OP_SE4) || (op == flash_status_pkg::OP_BE32)
			|| (op == flash_status_pkg::OP_BE64) || (op == flash_status_pkg::OP_SECE);
	endfunction

	function automatic logic is_prog(input logic [7:0] op);
		is_prog = (op == flash_status_pkg::OP_PP) || (op == flash_status_pkg::OP_QPP)
			|| (op == flash_status_pkg::OP_SECP);
	endfunction

	function automatic logic is_chip(input logic [7:0] op);
		is_chip = (op == flash_status_pkg::OP_CE1) || (op == flash_status_pkg::OP_CE2);
	endfunction

	// Serial clock domain, frame capture on rising edges
	logic frame_rst;
	logic started_r;
	logic rd_r;
	flash_status_pkg::rd_sel_t rsel_r;
	logic [7:0] sh_r;
	logic [7:0] op_r;
	logic [7:0] b1_r;
	logic [7:0] b2_r;
	logic [flash_status_pkg::LEN_W-1:0] len_r;
	logic [7:0] sh_nxt;
	logic [flash_status_pkg::LEN_W-1:0] len_nxt;
	logic op_here;

	// A chip select release clears the start, read and select flags at once, whatever bit is in flight
	assign frame_rst = rst | cs_n;
	assign sh_nxt = started_r ? {sh_r[6:0], si} : {7'h00, si};
	assign len_nxt = !started_r ? 6'h01 :
		(len_r == flash_status_pkg::LEN_MAX) ? len_r : len_r + 6'h01;
	assign op_here = len_nxt == flash_status_pkg::LEN_OP;

	always_ff @(posedge spi_clk or posedge frame_rst) begin
		if (frame_rst) begin
			started_r <= 1'b0;
			rd_r <= 1'b0;
			rsel_r <= flash_status_pkg::SEL_NONE;
		end else begin
			started_r <= 1'b1;
			if (op_here) begin
				rd_r <= rsel_of(sh_nxt) != flash_status_pkg::SEL_NONE;
				rsel_r <= rsel_of(sh_nxt);
			end
		end
	end

	// Kept past chip select so the system side can judge the finished frame
	always_ff @(posedge spi_clk or posedge rst) begin
		if (rst) begin
			sh_r <= 8'h00;
			len_r <= '0;
			op_r <= 8'h00;
			b1_r <= 8'h00;
			b2_r <= 8'h00;
		end else begin
			sh_r <= sh_nxt;
			len_r <= len_nxt;
			if (op_here)
				op_r <= sh_nxt;
			if (len_nxt == flash_status_pkg::LEN_B1)
				b1_r <= sh_nxt;
			if (len_nxt == flash_status_pkg::LEN_B2)
				b2_r <= sh_nxt;
		end
	end

	// Status snapshot handshake, serial clock side
	logic [1:0] req_s_r;
	logic ack_r;
	logic [1:0] qe_s_r;
	flash_status_pkg::status_t held_r;
	flash_status_pkg::status_t snap_r;
	logic req_r;

	always_ff @(posedge spi_clk or posedge rst) begin
		if (rst) begin
			req_s_r <= 2'h0;
			ack_r <= 1'b0;
			qe_s_r <= 2'h0;
			held_r <= '0;
		end else begin
			req_s_r <= {req_s_r[0], req_r};
			qe_s_r <= {qe_s_r[0], quad_io_enable};
			if (req_s_r[1] != ack_r) begin
				held_r <= snap_r;
				ack_r <= req_s_r[1];
			end
		end
	end

	// Shift out on falling edges
	logic [2:0] idx_r;
	logic [7:0] obyte_r;
	logic [7:0] cur;
	logic so_r;
	logic so_oe_r;
	logic wp_o_r;
	logic wp_oe_r;
	logic hold_o_r;
	logic hold_oe_r;
	logic quad_drv;

	assign cur = (rsel_r == flash_status_pkg::SEL_SR1) ? held_r.sr1 :
		(rsel_r == flash_status_pkg::SEL_SR2) ? held_r.sr2 : held_r.sr3;
	assign quad_drv = quad_doe & qe_s_r[1];

	always_ff @(negedge spi_clk or posedge frame_rst) begin
		if (frame_rst) begin
			so_r <= 1'b0;
			so_oe_r <= 1'b0;
			idx_r <= flash_status_pkg::IDX_MSB;
			obyte_r <= 8'h00;
			wp_o_r <= 1'b0;
			wp_oe_r <= 1'b0;
			hold_o_r <= 1'b0;
			hold_oe_r <= 1'b0;
		end else begin
			wp_o_r <= quad_dout[0];
			wp_oe_r <= quad_drv;
			hold_o_r <= quad_dout[1];
			hold_oe_r <= quad_drv;
			if (rd_r) begin
				so_oe_r <= 1'b1;
				idx_r <= idx_r - 3'h1;
				if (idx_r == flash_status_pkg::IDX_MSB) begin
					so_r <= cur[flash_status_pkg::IDX_MSB];
					obyte_r <= cur;
				end else begin
					so_r <= obyte_r[idx_r];
				end
			end
		end
	end

	assign so_o = so_r;
	assign so_oe = so_oe_r;
	assign wp_n_o = wp_o_r;
	assign wp_n_oe = wp_oe_r;
	assign hold_n_o = hold_o_r;
	assign hold_n_oe = hold_oe_r;

	// System clock domain: pin filters
	logic [2:0] cs_s_r;
	logic cs_f_r;
	logic [2:0] wp_s_r;
	logic wp_f_r;
	logic frame_end;

	assign frame_end = (cs_s_r[1] == cs_s_r[2]) && cs_s_r[2] && !cs_f_r;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cs_s_r <= 3'h7;
			cs_f_r <= 1'b1;
			wp_s_r <= 3'h7;
			wp_f_r <= 1'b1;
		end else begin
			cs_s_r <= {cs_s_r[1:0], cs_n};
			wp_s_r <= {wp_s_r[1:0], wp_n_i};
			if (cs_s_r[1] == cs_s_r[2])
				cs_f_r <= cs_s_r[2];
			if (wp_s_r[1] == wp_s_r[2])
				wp_f_r <= wp_s_r[2];
		end
	end

	// Status storage
	logic [7:0] nv1_r;
	logic [7:0] nv2_r;
	logic [7:0] nv3_r;
	logic wel_r;
	logic busy_r;
	logic esus_r;
	logic psus_r;
	logic start_r;
	logic [7:0] aop_r;
	logic protect_mode_hi;
	logic protect_mode_lo;
	logic wp_level;
	logic sr_locked;
	logic wr_cmd;
	logic wr_len_ok;
	logic do_wr;
	logic arr_cmd;
	logic arr_len_ok;
	logic [1:0] page;
	logic sec_ok;
	logic do_arr;
	logic abort;
	logic simple;
	logic wel_set;
	logic wel_clr;
	logic [7:0] nv1_nxt;
	logic [7:0] nv2_nxt;
	logic [7:0] nv3_nxt;

	assign protect_mode_hi = nv2_r[flash_status_pkg::B_HI];
	assign protect_mode_lo = nv1_r[flash_status_pkg::B_LO];
	// In quad mode the protect pin carries data and no longer guards writes
	assign wp_level = wp_f_r | nv2_r[flash_status_pkg::B_QE];
	// Pair 11 is undefined and is treated as locked down
	assign sr_locked = protect_mode_hi | (protect_mode_lo & !wp_level);

	assign wr_cmd = (op_r == flash_status_pkg::OP_WR1) || (op_r == flash_status_pkg::OP_WR2)
		|| (op_r == flash_status_pkg::OP_WR3);
	assign wr_len_ok = (len_r == flash_status_pkg::LEN_B1) ||
		((op_r == flash_status_pkg::OP_WR1) && (len_r == flash_status_pkg::LEN_B2));
	assign do_wr = frame_end && wr_cmd && wr_len_ok && wel_r && !sr_locked && !busy_r;

	assign arr_cmd = is_erase(op_r) || is_prog(op_r) || is_chip(op_r);
	assign arr_len_ok = is_chip(op_r) ? (len_r == flash_status_pkg::LEN_OP) :
		is_erase(op_r) ? (len_r == flash_status_pkg::LEN_ADDR) :
		(len_r >= flash_status_pkg::LEN_PROG);
	assign page = b2_r[flash_status_pkg::B_PAGE_HI:flash_status_pkg::B_PAGE_LO];
	assign sec_ok = ((op_r != flash_status_pkg::OP_SECP) && (op_r != flash_status_pkg::OP_SECE))
		|| ((page != 2'h0) && !nv2_r[flash_status_pkg::B_LB1 + {30'h0, page} - 1]);
	assign do_arr = frame_end && arr_cmd && arr_len_ok && wel_r && !busy_r && sec_ok;

	// Only a whole qualifying opcode may abort and drop the latch
	assign abort = frame_end && (len_r >= flash_status_pkg::LEN_OP) && wel_r &&
		(arr_cmd || wr_cmd) && !do_arr && !do_wr;
	assign simple = frame_end && (len_r == flash_status_pkg::LEN_OP);
	assign wel_set = simple && (op_r == flash_status_pkg::OP_WREN);
	assign wel_clr = (simple && (op_r == flash_status_pkg::OP_WRDI)) || do_wr || abort
		|| op_end;

	// Read-only positions keep hardware values; locks can only be set
	assign nv1_nxt = merge(nv1_r, b1_r, flash_status_pkg::SR1_RW);
	assign nv2_nxt = merge(nv2_r, (op_r == flash_status_pkg::OP_WR1) ? b2_r : b1_r,
		flash_status_pkg::SR2_RW) | (nv2_r & flash_status_pkg::SR2_LOCKS);
	assign nv3_nxt = merge(nv3_r, b1_r, flash_status_pkg::SR3_RW);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			nv1_r <= flash_status_pkg::SR1_RST;
			nv2_r <= flash_status_pkg::SR2_RST;
			nv3_r <= flash_status_pkg::SR3_RST;
			wel_r <= 1'b0;
			busy_r <= 1'b0;
			esus_r <= 1'b0;
			psus_r <= 1'b0;
			start_r <= 1'b0;
			aop_r <= 8'h00;
		end else begin
			busy_r <= busy_in;
			wel_r <= wel_set | (wel_r & !wel_clr);
			start_r <= do_arr;
			if (do_arr)
				aop_r <= op_r;
			if (do_wr && (op_r == flash_status_pkg::OP_WR1))
				nv1_r <= nv1_nxt;
			if (do_wr && ((op_r == flash_status_pkg::OP_WR2) ||
				((op_r == flash_status_pkg::OP_WR1) && (len_r == flash_status_pkg::LEN_B2))))
				nv2_r <= nv2_nxt;
			if (do_wr && (op_r == flash_status_pkg::OP_WR3))
				nv3_r <= nv3_nxt;
			// Suspend wins over resume when both somehow land together
			if (simple && (op_r == flash_status_pkg::OP_SUSP) && erase_active)
				esus_r <= 1'b1;
			else if (simple && (op_r == flash_status_pkg::OP_RESM))
				esus_r <= 1'b0;
			if (simple && (op_r == flash_status_pkg::OP_SUSP) && prog_active)
				psus_r <= 1'b1;
			else if (simple && (op_r == flash_status_pkg::OP_RESM))
				psus_r <= 1'b0;
		end
	end

	// Status snapshot handshake, system side
	flash_status_pkg::status_t status_now;
	logic [1:0] ack_s_r;

	always_comb begin
		status_now.sr1 = nv1_r & flash_status_pkg::SR1_RW;
		status_now.sr1[flash_status_pkg::B_WEL] = wel_r;
		status_now.sr1[flash_status_pkg::B_BUSY] = busy_r;
		status_now.sr2 = nv2_r & flash_status_pkg::SR2_RW;
		status_now.sr2[flash_status_pkg::B_ESUS] = esus_r;
		status_now.sr2[flash_status_pkg::B_PSUS] = psus_r;
		status_now.sr3 = nv3_r & flash_status_pkg::SR3_RW;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_s_r <= 2'h0;
			req_r <= 1'b0;
			snap_r <= '0;
		end else begin
			ack_s_r <= {ack_s_r[0], ack_r};
			if (ack_s_r[1] == req_r) begin
				snap_r <= status_now;
				req_r <= ~req_r;
			end
		end
	end

	assign array_start = start_r;
	assign array_op = aop_r;
	assign protect_cfg = {nv2_r[flash_status_pkg::B_INV], nv1_r[flash_status_pkg::B_GRAN],
		nv1_r[flash_status_pkg::B_TB],
		nv1_r[flash_status_pkg::B_AMT_HI:flash_status_pkg::B_AMT_LO]};
	assign drive_strength_sel = nv3_r[flash_status_pkg::B_DRV_HI:flash_status_pkg::B_DRV_LO];
	assign quad_io_enable = nv2_r[flash_status_pkg::B_QE];

	// Checks
	wp_lock_a: assert property (@(posedge sys_clk) disable iff (rst)
		(frame_end && !protect_mode_hi && protect_mode_lo && !wp_level) |=>
		$stable(nv1_r) && $stable(nv2_r) && $stable(nv3_r))
		else $error("status changed under pin protection");
	lockdown_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		protect_mode_hi |=> protect_mode_hi && $stable(nv1_r))
		else $error("lockdown left without power cycle");
	sw_write_a: assert property (@(posedge sys_clk) disable iff (rst)
		(frame_end && !protect_mode_hi && !protect_mode_lo && wel_r && !busy_r &&
		(op_r == flash_status_pkg::OP_WR3) && (len_r == flash_status_pkg::LEN_B1)) |=>
		drive_strength_sel == $past(b1_r[flash_status_pkg::B_DRV_HI:flash_status_pkg::B_DRV_LO]))
		else $error("software protected write not taken");
	rsv_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		(nv3_r & ~flash_status_pkg::SR3_RW) == 8'h00)
		else $error("reserved bits not zero");
	wel_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
		(frame_end && !wel_r) |=> !array_start && $stable(nv1_r))
		else $error("command taken without write enable");
	wel_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
		(abort || do_wr) && !wel_set |=> !wel_r)
		else $error("latch kept after write or abort");
	short_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
		(frame_end && (len_r < flash_status_pkg::LEN_OP) && wel_r && !op_end) |=> wel_r)
		else $error("latch lost on partial opcode");
	sec_lock_a: assert property (@(posedge sys_clk) disable iff (rst)
		(frame_end && !sec_ok) |=> !array_start)
		else $error("locked security page started");
	esus_set_a: assert property (@(posedge sys_clk) disable iff (rst)
		(simple && (op_r == flash_status_pkg::OP_SUSP) && erase_active) |=> ##1
		status_now.sr2[flash_status_pkg::B_ESUS])
		else $error("erase suspend flag not set");
	busy_view_a: assert property (@(posedge sys_clk) disable iff (rst)
		busy_in |=> status_now.sr1[flash_status_pkg::B_BUSY])
		else $error("busy not shown");
	so_float_a: assert property (@(posedge sys_clk) disable iff (rst)
		(cs_s_r[1] && cs_s_r[2]) |-> !so_oe)
		else $error("output driven without chip select");
	rd_cov_c: cover property (@(posedge sys_clk) disable iff (rst) so_oe ##[1:40] frame_end);
	wr_cov_c: cover property (@(posedge sys_clk) disable iff (rst) do_wr);
	lock_cov_c: cover property (@(posedge sys_clk) disable iff (rst) frame_end && protect_mode_hi);
	// A status read sits between suspend and resume, so the span is long
	susp_cov_c: cover property (@(posedge sys_clk) disable iff (rst) esus_r ##[1:1000] !esus_r);
endmodule

// ==== dv/spi_host_model.sv ====
// Purpose: SPI host model that drives chip select, serial clock and data
// Assumes: Mode 0; serial clock stands low outside frames
// Notes: A released data line reads as the inverse of the last bit taken
`timescale 1ns/1ps
module spi_host_model (
	// Serial pins
	output logic cs_n,
	output logic spi_clk,
	output logic si,
	input wire logic so_o,
	input wire logic so_oe
);
	logic last_bit;
	initial begin
		cs_n = 1'b1;
		spi_clk = 1'b0;
		si = 1'b0;
		last_bit = 1'b0;
	end
	// Sends n bits of d from the top, then clocks nr bits back, MSB first
	task automatic xfer(input logic [39:0] d, input int n, input int nr, output logic [15:0] q);
		q = 16'h0000;
		cs_n = 1'b0;
		for (int i = 0; i < n + nr; i++) begin
			si = (i < n) ? d[39 - i] : 1'b0;
			#24 spi_clk = 1'b1;
			if (i >= n) begin
				last_bit = so_oe ? so_o : ~last_bit;
				q = {q[14:0], last_bit};
			end
			#24 spi_clk = 1'b0;
		end
		// Host may end the frame at any bit
		#24 cs_n = 1'b1;
		#24;
	endtask
endmodule

// ==== dv/flash_status_regs_tb.sv ====
// Purpose: Self-checking bench for the flash status register logic
// Assumes: Host model frames commands; system inputs change on falling sys_clk
// Notes: Reads keep the second byte, since the first may predate the frame
`timescale 1ns/1ps
module flash_status_regs_tb;
	logic sys_clk, rst, cs_n, spi_clk, si, so_o, so_oe, wp_pin, wp_n_o, wp_n_oe;
	logic hold_n_o, hold_n_oe, wp_w, hold_w, quad_doe, busy_in, erase_active, prog_active;
	logic op_end, array_start, quad_io_enable, quad_seen;
	logic [1:0] quad_dout, drive_strength_sel;
	logic [7:0] array_op, last_op, r;
	logic [15:0] q;
	flash_status_pkg::prot_cfg_t protect_cfg;
	int fail_count, check_count, starts, s0;
	// Shared pins resolve from every driver; hold has a pull-up
	assign wp_w = wp_n_oe ? wp_n_o : wp_pin;
	assign hold_w = hold_n_oe ? hold_n_o : 1'b1;
	flash_status_regs uut (.sys_clk(sys_clk), .rst(rst), .spi_clk(spi_clk), .cs_n(cs_n),
		.si(si), .so_o(so_o), .so_oe(so_oe), .wp_n_i(wp_w), .wp_n_o(wp_n_o),
		.wp_n_oe(wp_n_oe), .hold_n_i(hold_w), .hold_n_o(hold_n_o), .hold_n_oe(hold_n_oe),
		.quad_dout(quad_dout), .quad_doe(quad_doe), .busy_in(busy_in),
		.erase_active(erase_active), .prog_active(prog_active), .op_end(op_end),
		.array_start(array_start), .array_op(array_op), .protect_cfg(protect_cfg),
		.drive_strength_sel(drive_strength_sel), .quad_io_enable(quad_io_enable));
	spi_host_model host (.cs_n(cs_n), .spi_clk(spi_clk), .si(si), .so_o(so_o), .so_oe(so_oe));
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) begin
		if (array_start === 1'b1) begin
			starts++;
			last_op = array_op;
		end
	end
	always @(posedge spi_clk) begin
		if (wp_n_oe === 1'b1 && hold_n_oe === 1'b1 && {hold_n_o, wp_n_o} === quad_dout)
			quad_seen = 1'b1;
	end
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic gap();
		repeat (20) @(negedge sys_clk);
	endtask
	task automatic cmd(input logic [39:0] d, input int n);
		logic [15:0] qq;
		host.xfer(d, n, 0, qq);
		gap();
	endtask
	task automatic rd(input logic [7:0] op);
		logic [15:0] qq;
		host.xfer({op, 32'h0}, 8, 16, qq);
		r = qq[7:0];
		gap();
	endtask
	task automatic wren();
		cmd({flash_status_pkg::OP_WREN, 32'h0}, 8);
	endtask
	task automatic report_and_stop();
		if (fail_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#400us;
		fail_count++;
		report_and_stop();
	end
	initial begin
		{rst, wp_pin, quad_dout, quad_doe, busy_in} = 6'h3C;
		{erase_active, prog_active, op_end, quad_seen} = 4'h0;
		{fail_count, check_count, starts} = 0;
		repeat (6) @(negedge sys_clk);
		rst = 1'b0;
		repeat (8) @(negedge sys_clk);
		rd(flash_status_pkg::OP_RD3);
		chk("sr3", r, 8'h60);
		rd(flash_status_pkg::OP_RD1);
		chk("sr1", r, 8'h00);
		host.xfer({flash_status_pkg::OP_RD1, 32'h0}, 8, 3, q);
		chk("so_oe", {7'h00, so_oe}, 8'h00);
		gap();
		cmd({flash_status_pkg::OP_WR3, 8'h40, 24'h0}, 16);
		chk("drv", {6'h00, drive_strength_sel}, 8'h03);
		wren();
		rd(flash_status_pkg::OP_RD1);
		chk("sr1", r, 8'h02);
		cmd({flash_status_pkg::OP_WR3, 8'h9F, 24'h0}, 16);
		chk("drv", {6'h00, drive_strength_sel}, 8'h00);
		rd(flash_status_pkg::OP_RD3);
		chk("sr3", r, 8'h00);
		rd(flash_status_pkg::OP_RD1);
		chk("sr1", r, 8'h00);
		// Short frame keeps the latch, a full but refused opcode drops it
		wren();
		cmd({flash_status_pkg::OP_PP, 32'h0}, 4);
		rd(flash_status_pkg::OP_RD1);
		chk("sr1", r, 8'h02);
		cmd({flash_status_pkg::OP_PP, 32'h0}, 8);
		rd(flash_status_pkg::OP_RD1);
		chk("sr1", r, 8'h00);
		cmd({flash_status_pkg::OP_PP, 32'h0}, 40);
		chk("starts", starts[7:0], 8'h00);
		wren();
		cmd({flash_status_pkg::OP_PP, 32'h0}, 40);
		chk("starts", starts[7:0], 8'h01);
		chk("op", last_op, flash_status_pkg::OP_PP);
		op_end = 1'b1;
		@(negedge sys_clk);
		op_end = 1'b0;
		rd(flash_status_pkg::OP_RD1);
		chk("sr1", r, 8'h00);
		wren();
		cmd({flash_status_pkg::OP_WRDI, 32'h0}, 8);
		rd(flash_status_pkg::OP_RD1);
		chk("sr1", r, 8'h00);
		wren();
		cmd({flash_status_pkg::OP_SE4, 32'h0}, 32);
		chk("op", last_op, flash_status_pkg::OP_SE4);
		wren();
		cmd({flash_status_pkg::OP_CE2, 32'h0}, 8);
		chk("starts", starts[7:0], 8'h03);
		chk("op", last_op, flash_status_pkg::OP_CE2);
		op_end = 1'b1;
		@(negedge sys_clk);
		op_end = 1'b0;
		wren();
		cmd({flash_status_pkg::OP_WR1, 8'h80, 24'h0}, 16);
		rd(flash_status_pkg::OP_RD1);
		chk("sr1", r, 8'h80);
		wp_pin = 1'b0;
		wren();
		cmd({flash_status_pkg::OP_WR3, 8'h40, 24'h0}, 16);
		chk("drv", {6'h00, drive_strength_sel}, 8'h00);
		wp_pin = 1'b1;
		wren();
		cmd({flash_status_pkg::OP_WR3, 8'h40, 24'h0}, 16);
		chk("drv", {6'h00, drive_strength_sel}, 8'h02);
		busy_in = 1'b1;
		rd(flash_status_pkg::OP_RD1);
		chk("sr1", r, 8'h81);
		fork
			begin
				repeat (300) @(negedge sys_clk);
				busy_in = 1'b0;
			end
			for (int i = 0; i < 40 && r[0] !== 1'b0; i++) rd(flash_status_pkg::OP_RD1);
		join
		chk("sr1", r, 8'h80);
		for (int k = 0; k < 2; k++) begin
			erase_active = (k == 0);
			prog_active = (k == 1);
			cmd({flash_status_pkg::OP_SUSP, 32'h0}, 8);
			rd(flash_status_pkg::OP_RD2);
			chk("sr2", r, (k == 0) ? 8'h80 : 8'h04);
			cmd({flash_status_pkg::OP_RESM, 32'h0}, 8);
			rd(flash_status_pkg::OP_RD2);
			chk("sr2", r, 8'h00);
		end
		{erase_active, prog_active, quad_doe} = 3'h1;
		rd(flash_status_pkg::OP_RD1);
		chk("quad_oe", {7'h00, quad_seen}, 8'h00);
		wren();
		cmd({flash_status_pkg::OP_WR2, 8'h0A, 24'h0}, 16);
		chk("qe", {7'h00, quad_io_enable}, 8'h01);
		rd(flash_status_pkg::OP_RD2);
		chk("sr2", r, 8'h0A);
		rd(flash_status_pkg::OP_RD1);
		chk("quad_oe", {7'h00, quad_seen}, 8'h01);
		quad_doe = 1'b0;
		s0 = starts;
		wren();
		cmd({flash_status_pkg::OP_SECP, 8'h00, 8'h10, 16'h0}, 40);
		chk("starts", starts[7:0], s0[7:0]);
		wren();
		cmd({flash_status_pkg::OP_SECP, 8'h00, 8'h20, 16'h0}, 40);
		chk("starts", starts[7:0], s0[7:0] + 8'h01);
		chk("op", last_op, flash_status_pkg::OP_SECP);
		wren();
		cmd({flash_status_pkg::OP_WR1, 8'h54, 8'h41, 16'h0}, 24);
		chk("cfg", {2'h0, protect_cfg}, 8'h35);
		rd(flash_status_pkg::OP_RD1);
		chk("sr1", r, 8'h54);
		wren();
		cmd({flash_status_pkg::OP_WR3, 8'h60, 24'h0}, 16);
		chk("drv", {6'h00, drive_strength_sel}, 8'h02);
		// A reset stands in for the power cycle that lifts the lock
		rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		repeat (8) @(negedge sys_clk);
		chk("drv", {6'h00, drive_strength_sel}, 8'h03);
		rd(flash_status_pkg::OP_RD2);
		chk("sr2", r, 8'h00);
		rd(flash_status_pkg::OP_RD1);
		chk("sr1", r, 8'h00);
		wren();
		cmd({flash_status_pkg::OP_WR3, 8'h40, 24'h0}, 16);
		chk("drv", {6'h00, drive_strength_sel}, 8'h02);
		report_and_stop();
	end
endmodule
